// ---- design/gtp_pkg.sv ----
package gtp_pkg;

   typedef enum logic [1:0] {
      GTP_SP_IDLE  = 2'h0,
      GTP_SP_WAIT  = 2'h1,
      GTP_SP_PULSE = 2'h3
   } gtp_sp_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gtp_bus_type;

   // Pin order: comp2, comp1, gate pin, secondary osc, ext clock pin
   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [4:0]  s3;
      logic [4:0]  flt;
      logic        clkPrev;
      logic        extDly;
      logic [1:0]  instr;
      logic [7:0]  ctl;
      logic [7:0]  gctl;
      gtp_sp_type  sp;
      logic        tgl;
      logic        gpPrev;
      logic        selPrev;
      logic        valPrev;
      logic [2:0]  pre;
      logic [15:0] cnt;
      logic [7:0]  hiBuf;
      logic [7:0]  pcnt;
      logic [7:0]  plim;
      logic [6:0]  pctl;
      logic [3:0]  ppre;
      logic [3:0]  ppost;
      logic        match;
      logic [2:0]  flags;
      logic [3:0]  irqEn;
      logic [7:0]  rdata;
   } gtp_state_type;

endpackage : gtp_pkg

// ---- design/gtp_regs.svh ----
`ifndef GTP_REGS_SVH
`define GTP_REGS_SVH

// =====================================================================
// Register offsets
`define GTP_ADDR_WIDE_CTL     4'h0
`define GTP_ADDR_WIDE_GATE    4'h1
`define GTP_ADDR_CNT_LOW      4'h2
`define GTP_ADDR_CNT_HIGH     4'h3
`define GTP_ADDR_PER_COUNT    4'h4
`define GTP_ADDR_PER_LIMIT    4'h5
`define GTP_ADDR_PER_CTL      4'h6
`define GTP_ADDR_FLAGS        4'h7
`define GTP_ADDR_IRQ_EN       4'h8

// =====================================================================
// Wide timer control fields
`define GTP_CS_HI             7
`define GTP_CS_LO             6
`define GTP_CKPS_HI           5
`define GTP_CKPS_LO           4
`define GTP_SOSC_EN           3
`define GTP_SYNC_DIS          2
`define GTP_WIDE_ACC          1
`define GTP_RUN               0

// =====================================================================
// Wide timer gate control fields
`define GTP_GATE_EN           7
`define GTP_GATE_POL          6
`define GTP_GATE_TGL          5
`define GTP_GATE_SPM          4
`define GTP_GATE_ARM          3
`define GTP_GATE_VAL          2
`define GTP_GSS_HI            1
`define GTP_GSS_LO            0

// =====================================================================
// Period timer control fields
`define GTP_OUTPS_HI          6
`define GTP_OUTPS_LO          3
`define GTP_PER_RUN           2
`define GTP_PCKPS_HI          1
`define GTP_PCKPS_LO          0

// =====================================================================
// Flag and enable fields
`define GTP_FLAG_GATE         0
`define GTP_FLAG_ROLL         1
`define GTP_FLAG_PER          2
`define GTP_EN_PER_PRIO       3

// =====================================================================
// Reset values and timing
`define GTP_RST_CTL           8'h00
`define GTP_RST_GATE          8'h00
`define GTP_RST_PER_LIMIT     8'hff
`define GTP_RST_PER_CTL       7'h00
`define GTP_INSTR_LAST        2'h3
`define GTP_SERIAL_TMR_MODE   4'h3

`endif

// ---- design/gtp_timer_block.sv ----
//Behaviour
// - External source: sync-disable 1 unsynchronised, 0 synchronised; ignored for 0X.
// - Wide-access enable gives one 16-bit read or write via high-byte buffer.
// - Toggle mode routes gate through flop toggling on rising edges; off clears it.
// - Single-pulse mode bit lets single-pulse logic own the gate.
// - Arm bit set by software, reads 1 while waiting, cleared by hardware.
// - Count from next rising edge, disarm at trailing edge; mode off disarms.
// - Gate level bit shows gate state regardless of gate enable.
// - Gate source 00 pin, 01 period match, 10 comparator 1, 11 comparator 2.
// - Falling gate level sets gate event flag, even with gate disabled.
// - Wide count wraps FFFF to 0000 and sets rollover flag.
// - Power-on reset clears both control registers; other resets clear wide access only.
// - Period timer runs on instruction clock, counting up from zero.
// - Four-bit prescaler before period timer divides by 1, 4 or 16.
// - Count equals limit gives match, counter back to zero, postscaler advanced.
// - Each period counter reset sends one rising pulse to the gate logic.
// - Period counter clears on any reset; period limit resets to all ones.
// - Prescaler and postscaler clear on count write, control write, any reset.
// - Writing period control leaves the period count unchanged.
// - Postscale code n gives ratio 1:(n+1), up to 1:16.
// - Postscaler output sets period flag; interrupt by enable, with priority bit.
// - Unscaled match is the PWM time base and serial shift clock for mode 0011.
// - During sleep the period timer holds count and limit.
// - Module disable holds that timer in reset with its clock cut.
`include "gtp_regs.svh"

module gtp_timer_block (
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                porBor,
   input  wire gtp_pkg::gtp_bus_type bus,
   output logic [7:0]               rdata,
   input  wire logic                extClockPin,
   input  wire logic                secOscClock,
   input  wire logic                gatePin,
   input  wire logic                comp1Out,
   input  wire logic                comp2Out,
   input  wire logic                sleep,
   input  wire logic                wideTimerDisable,
   input  wire logic                periodTimerDisable,
   input  wire logic [3:0]          serialModeSelect,
   output logic                     periodMatch,
   output logic                     serialShiftClock,
   output logic                     gateEventIrq,
   output logic                     rolloverIrq,
   output logic                     periodMatchIrq,
   output logic                     periodMatchHighPrio
);

   gtp_pkg::gtp_state_type q;
   gtp_pkg::gtp_state_type d;

   logic [4:0] pinsNow;
   logic       wrWideCtl;
   logic       wrGate;
   logic       wrLow;
   logic       wrHigh;
   logic       wrPCount;
   logic       wrPCtl;
   logic       rdLow;
   logic       srcEdge;
   logic       extEdge;
   logic       isExt;
   logic       preHit;
   logic       gp;
   logic       gSel;
   logic       gVal;
   logic       srcRaw;
   logic       cntEn;
   logic       pTick;
   logic       pStep;
   logic       pHit;
   logic [7:0] rdNext;

   assign pinsNow  = {comp2Out, comp1Out, gatePin, secOscClock, extClockPin};
   assign wrWideCtl = bus.wr && bus.addr == `GTP_ADDR_WIDE_CTL;
   assign wrGate   = bus.wr && bus.addr == `GTP_ADDR_WIDE_GATE;
   assign wrLow    = bus.wr && bus.addr == `GTP_ADDR_CNT_LOW;
   assign wrHigh   = bus.wr && bus.addr == `GTP_ADDR_CNT_HIGH;
   assign wrPCount = bus.wr && bus.addr == `GTP_ADDR_PER_COUNT;
   assign wrPCtl   = bus.wr && bus.addr == `GTP_ADDR_PER_CTL;
   assign rdLow    = bus.rd && bus.addr == `GTP_ADDR_CNT_LOW;

   // ==================================================================
   // Wide timer clock source and prescaler
   always_comb
   begin
      logic clkSel;
      clkSel = q.ctl[`GTP_SOSC_EN] ? q.flt[1] : q.flt[0];
      extEdge = clkSel && !q.clkPrev;
      isExt = q.ctl[`GTP_CS_HI:`GTP_CS_LO] == 2'b10;
      case (q.ctl[`GTP_CS_HI:`GTP_CS_LO])
         2'b00:   srcEdge = q.instr == `GTP_INSTR_LAST;
         2'b01:   srcEdge = 1'b1;
         // Synchronised path adds one system-clock stage
         2'b10:   srcEdge = q.ctl[`GTP_SYNC_DIS] ? extEdge : q.extDly;
         default: srcEdge = 1'b0;
      endcase
      // Internal and synchronised sources stop in sleep
      if (sleep && !(isExt && q.ctl[`GTP_SYNC_DIS]))
      begin
         srcEdge = 1'b0;
      end
      case (q.ctl[`GTP_CKPS_HI:`GTP_CKPS_LO])
         2'b11:   preHit = q.pre == 3'h7;
         2'b10:   preHit = q.pre[1:0] == 2'h3;
         2'b01:   preHit = q.pre[0];
         default: preHit = 1'b1;
      endcase
   end

   // ==================================================================
   // Gate path
   always_comb
   begin
      case (q.gctl[`GTP_GSS_HI:`GTP_GSS_LO])
         2'b00:   srcRaw = q.flt[2];
         2'b01:   srcRaw = q.match;
         2'b10:   srcRaw = q.flt[3];
         default: srcRaw = q.flt[4];
      endcase
      gp = srcRaw ~^ q.gctl[`GTP_GATE_POL];
      gSel = q.gctl[`GTP_GATE_TGL] ? q.tgl : gp;
      // Single pulse passes the gate only during the captured pulse
      gVal = q.gctl[`GTP_GATE_SPM] ? (q.sp == gtp_pkg::GTP_SP_PULSE) && gSel : gSel;
      cntEn = q.ctl[`GTP_RUN] && srcEdge && preHit
              && (!q.gctl[`GTP_GATE_EN] || gVal);
   end

   // ==================================================================
   // Period timer tick
   always_comb
   begin
      pTick = 1'b0;
      pStep = q.instr == `GTP_INSTR_LAST && q.pctl[`GTP_PER_RUN] && !sleep;
      if (pStep)
      begin
         case (q.pctl[`GTP_PCKPS_HI:`GTP_PCKPS_LO])
            2'b00:   pTick = 1'b1;
            2'b01:   pTick = q.ppre[1:0] == 2'h3;
            default: pTick = q.ppre == 4'hf;
         endcase
      end
      pHit = pTick && q.pcnt == q.plim;
   end

   // ==================================================================
   // Read mux
   always_comb
   begin
      case (bus.addr)
         `GTP_ADDR_WIDE_CTL:  rdNext = q.ctl;
         `GTP_ADDR_WIDE_GATE: rdNext = {q.gctl[7:4], q.sp != gtp_pkg::GTP_SP_IDLE,
                                        gVal, q.gctl[1:0]};
         `GTP_ADDR_CNT_LOW:   rdNext = q.cnt[7:0];
         `GTP_ADDR_CNT_HIGH:  rdNext = q.ctl[`GTP_WIDE_ACC] ? q.hiBuf : q.cnt[15:8];
         `GTP_ADDR_PER_COUNT: rdNext = q.pcnt;
         `GTP_ADDR_PER_LIMIT: rdNext = q.plim;
         `GTP_ADDR_PER_CTL:   rdNext = {1'b0, q.pctl};
         `GTP_ADDR_FLAGS:     rdNext = {5'h00, q.flags};
         `GTP_ADDR_IRQ_EN:    rdNext = {4'h0, q.irqEn};
         default:             rdNext = 8'h00;
      endcase
   end

   // ==================================================================
   // Next state
   always_comb
   begin
      d = q;
      d.s1 = pinsNow;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // A change counts once the last two stages agree
      d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
      d.clkPrev = q.ctl[`GTP_SOSC_EN] ? q.flt[1] : q.flt[0];
      d.extDly = extEdge;
      d.instr = q.instr + 2'h1;
      d.rdata = bus.rd ? rdNext : 8'h00;
      d.gpPrev = gp;
      d.selPrev = gSel;
      d.valPrev = gVal;
      d.match = 1'b0;

      // Toggle flop
      if (!q.gctl[`GTP_GATE_TGL] || !q.ctl[`GTP_RUN])
      begin
         d.tgl = 1'b0;
      end
      else if (gp && !q.gpPrev)
      begin
         d.tgl = !q.tgl;
      end

      // Single-pulse sequence
      case (q.sp)
         gtp_pkg::GTP_SP_WAIT:
         begin
            if (gSel && !q.selPrev)
            begin
               d.sp = gtp_pkg::GTP_SP_PULSE;
            end
         end
         gtp_pkg::GTP_SP_PULSE:
         begin
            if (!gSel && q.selPrev)
            begin
               d.sp = gtp_pkg::GTP_SP_IDLE;
            end
         end
         default: d.sp = gtp_pkg::GTP_SP_IDLE;
      endcase
      if (!q.gctl[`GTP_GATE_SPM])
      begin
         d.sp = gtp_pkg::GTP_SP_IDLE;
      end
      if (wrGate && bus.wdata[`GTP_GATE_ARM] && bus.wdata[`GTP_GATE_SPM]
          && q.sp == gtp_pkg::GTP_SP_IDLE)
      begin
         d.sp = gtp_pkg::GTP_SP_WAIT;
      end

      // Wide counter
      if (q.ctl[`GTP_RUN] && srcEdge)
      begin
         d.pre = preHit ? 3'h0 : q.pre + 3'h1;
      end
      if (cntEn)
      begin
         d.cnt = q.cnt + 16'h0001;
      end
      if (wrWideCtl)
      begin
         d.ctl = bus.wdata;
      end
      if (wrGate)
      begin
         d.gctl = bus.wdata;
      end
      if (rdLow && q.ctl[`GTP_WIDE_ACC])
      begin
         d.hiBuf = q.cnt[15:8];
      end
      // Bus writes take precedence over counting
      if (wrHigh)
      begin
         if (q.ctl[`GTP_WIDE_ACC])
         begin
            d.hiBuf = bus.wdata;
         end
         else
         begin
            d.cnt[15:8] = bus.wdata;
         end
      end
      if (wrLow)
      begin
         d.cnt[7:0] = bus.wdata;
         if (q.ctl[`GTP_WIDE_ACC])
         begin
            d.cnt[15:8] = q.hiBuf;
         end
      end

      // Period timer
      if (pStep)
      begin
         d.ppre = q.ppre + 4'h1;
      end
      if (pTick)
      begin
         d.pcnt = pHit ? 8'h00 : q.pcnt + 8'h01;
      end
      if (pHit)
      begin
         d.match = 1'b1;
         d.ppost = q.ppost + 4'h1;
         if (q.ppost == q.pctl[`GTP_OUTPS_HI:`GTP_OUTPS_LO])
         begin
            d.ppost = 4'h0;
         end
      end
      if (wrPCount)
      begin
         d.pcnt = bus.wdata;
      end
      if (bus.wr && bus.addr == `GTP_ADDR_PER_LIMIT)
      begin
         d.plim = bus.wdata;
      end
      if (wrPCtl)
      begin
         d.pctl = bus.wdata[6:0];
      end
      if (wrPCount || wrPCtl)
      begin
         d.ppre = 4'h0;
         d.ppost = 4'h0;
      end

      // Flags: writing 0 clears, a same-cycle event still sets
      if (bus.wr && bus.addr == `GTP_ADDR_FLAGS)
      begin
         d.flags = q.flags & bus.wdata[2:0];
      end
      if (bus.wr && bus.addr == `GTP_ADDR_IRQ_EN)
      begin
         d.irqEn = bus.wdata[3:0];
      end
      if (!gVal && q.valPrev)
      begin
         d.flags[`GTP_FLAG_GATE] = 1'b1;
      end
      if (cntEn && q.cnt == 16'hffff)
      begin
         d.flags[`GTP_FLAG_ROLL] = 1'b1;
      end
      if (pHit && q.ppost == q.pctl[`GTP_OUTPS_HI:`GTP_OUTPS_LO])
      begin
         d.flags[`GTP_FLAG_PER] = 1'b1;
      end

      // Module disable holds each timer in reset
      if (wideTimerDisable)
      begin
         d.ctl = `GTP_RST_CTL;
         d.gctl = `GTP_RST_GATE;
         d.cnt = 16'h0000;
         d.hiBuf = 8'h00;
         d.pre = 3'h0;
         d.tgl = 1'b0;
         d.sp = gtp_pkg::GTP_SP_IDLE;
      end
      if (periodTimerDisable)
      begin
         d.pcnt = 8'h00;
         d.plim = `GTP_RST_PER_LIMIT;
         d.pctl = `GTP_RST_PER_CTL;
         d.ppre = 4'h0;
         d.ppost = 4'h0;
         d.match = 1'b0;
      end

      if (!nrst)
      begin
         if (porBor)
         begin
            d = '0;
            d.ctl = `GTP_RST_CTL;
            d.gctl = `GTP_RST_GATE;
            d.sp = gtp_pkg::GTP_SP_IDLE;
         end
         else
         begin
            d = q;
            d.ctl[`GTP_WIDE_ACC] = 1'b0;
            d.rdata = 8'h00;
            d.match = 1'b0;
         end
         d.pcnt = 8'h00;
         d.plim = `GTP_RST_PER_LIMIT;
         d.pctl = `GTP_RST_PER_CTL;
         d.ppre = 4'h0;
         d.ppost = 4'h0;
      end
   end

   // ==================================================================
   // State register
   always_ff @(posedge clock)
   begin
      q <= d;
   end

   // ==================================================================
   // Outputs
   assign rdata = q.rdata;
   assign periodMatch = q.match;
   assign serialShiftClock = q.match && serialModeSelect == `GTP_SERIAL_TMR_MODE;
   assign gateEventIrq = q.flags[`GTP_FLAG_GATE] && q.irqEn[`GTP_FLAG_GATE];
   assign rolloverIrq = q.flags[`GTP_FLAG_ROLL] && q.irqEn[`GTP_FLAG_ROLL];
   assign periodMatchIrq = q.flags[`GTP_FLAG_PER] && q.irqEn[`GTP_FLAG_PER];
   assign periodMatchHighPrio = q.irqEn[`GTP_EN_PER_PRIO];

endmodule : gtp_timer_block

// ---- dv/gtp_chk.sv ----
module gtp_chk (
   input wire logic                 clock,
   input wire logic                 nrst,
   input wire logic                 porBor,
   input wire gtp_pkg::gtp_bus_type bus,
   input wire logic [7:0]           rdata,
   input wire logic                 sleep,
   input wire logic                 periodTimerDisable,
   input wire logic [3:0]           serialModeSelect,
   input wire logic                 periodMatch,
   input wire logic                 serialShiftClock,
   input wire logic                 gateEventIrq,
   input wire logic                 rolloverIrq,
   input wire logic                 periodMatchIrq,
   input wire logic                 periodMatchHighPrio
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // ==========
   // Sequences
   sequence sSleeping;
      sleep [*3];
   endsequence
   sequence sDisabled;
      periodTimerDisable [*3];
   endsequence
   sequence sPorReset;
      !nrst && porBor;
   endsequence

   // ==========
   // Properties
   rdata_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   shift_clock_a: assert property (serialShiftClock == (periodMatch && serialModeSelect == 4'h3))
      else $error("shift clock differs from match");
   match_pulse_a: assert property (periodMatch |=> !periodMatch [*3])
      else $error("match pulse too long or too close");
   sleep_hold_a: assert property (sSleeping |-> !periodMatch)
      else $error("match while asleep");
   disable_hold_a: assert property (sDisabled |-> !periodMatch)
      else $error("match while disabled");
   por_clear_a: assert property (disable iff (1'b0) sPorReset |=>
      !rolloverIrq && !gateEventIrq && !periodMatchIrq && !periodMatchHighPrio)
      else $error("flags survive power-on reset");
   reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> rdata == 8'h00 && !periodMatch)
      else $error("outputs active in reset");
   match_irq_cause_a: assert property ($rose(periodMatchIrq) |->
      $past(bus.wr) || periodMatch || $past(periodMatch) || $past(periodMatch, 2))
      else $error("period interrupt without match");
endmodule : gtp_chk

bind gtp_timer_block gtp_chk chk_u (.clock, .nrst, .porBor, .bus, .rdata, .sleep,
   .periodTimerDisable, .serialModeSelect, .periodMatch, .serialShiftClock, .gateEventIrq,
   .rolloverIrq, .periodMatchIrq, .periodMatchHighPrio);

// ---- dv/gtp_pins_model.sv ----
module gtp_pins_model (
   input  wire logic clock,
   input  wire logic gateLevel,
   input  wire logic go,
   output logic      extClockPin,
   output logic      secOscClock,
   output logic      gatePin,
   output logic      comp1Out,
   output logic      comp2Out,
   output logic      done
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int EDGES = 9;

   initial
   begin
      extClockPin = 1'b0;
      secOscClock = 1'b0;
      done = 1'b1;
   end

   // Crystal runs whether or not it is selected
   always #15259 secOscClock = ~secOscClock;

   assign gatePin  = gateLevel;
   assign comp1Out = gateLevel;
   assign comp2Out = !gateLevel;

   // Pin clock rests low between bursts
   always @(posedge go)
   begin
      done = 1'b0;
      repeat (EDGES)
      begin
         repeat (4) @(posedge clock);
         #7 extClockPin = 1'b1;
         repeat (4) @(posedge clock);
         #7 extClockPin = 1'b0;
      end
      done = 1'b1;
   end
endmodule : gtp_pins_model

// ---- dv/gtp_timer_block_tb_top.sv ----
module gtp_timer_block_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic                 clock = 1'b0;
   logic                 nrst = 1'b0;
   logic                 porBor = 1'b1;
   gtp_pkg::gtp_bus_type bus = '0;
   logic                 sleep = 1'b0;
   logic                 wideTimerDisable = 1'b0;
   logic                 periodTimerDisable = 1'b0;
   logic [3:0]           serialModeSelect = 4'h3;
   logic                 gateLevel = 1'b0;
   logic                 go = 1'b0;
   logic                 rdLast = 1'b0;
   logic [7:0]           rdata;
   logic                 extClockPin, secOscClock, gatePin, comp1Out, comp2Out, pinsDone;
   logic                 periodMatch, serialShiftClock, gateEventIrq;
   logic                 rolloverIrq, periodMatchIrq, periodMatchHighPrio;
   logic [15:0]          expQ [$];
   logic [15:0]          note;
   logic [31:0]          seed = 32'h6d209415;
   logic [7:0]           ec [3] = '{8'h83, 8'h87, 8'hc3};
   int                   pv [3] = '{0, 3, 15};
   int                   fail_count = 0;
   int                   num_checks = 0;
   int                   n;
   int                   e;

   always #25 clock = ~clock;

   gtp_timer_block dut_u (.clock, .nrst, .porBor, .bus, .rdata, .extClockPin, .secOscClock,
      .gatePin, .comp1Out, .comp2Out, .sleep, .wideTimerDisable, .periodTimerDisable,
      .serialModeSelect, .periodMatch, .serialShiftClock, .gateEventIrq, .rolloverIrq,
      .periodMatchIrq, .periodMatchHighPrio);

   gtp_pins_model pins_u (.clock, .gateLevel, .go, .extClockPin, .secOscClock, .gatePin,
      .comp1Out, .comp2Out, .done(pinsDone));

   // ==========
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic op(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clock);
      bus <= '0;
   endtask : op

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      op(a, d, 1'b1);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
      expQ.push_back({m, x});
      op(a, 8'h00, 1'b0);
   endtask : rd

   // Sampling on the falling edge keeps clear of the design's updates
   task automatic waitHi(ref logic s, input int lim, output int cnt);
      cnt = 0;
      do
      begin
         @(negedge clock);
         cnt++;
      end
      while (s !== 1'b1 && cnt < lim);
   endtask : waitHi

   task automatic reset(input logic por);
      porBor <= por;
      nrst <= 1'b0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
   endtask : reset

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   always @(posedge clock)
   begin
      rdLast <= bus.rd;
      if (rdLast)
      begin
         note = expQ.pop_front();
         check(rdata & note[15:8], note[7:0] & note[15:8]);
      end
   end

   // ==========
   // Scenarios
   initial
   begin
      reset(1'b1);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00, 8'hfb);
      rd(4'h4, 8'h00);
      rd(4'h5, 8'hff);
      rd(4'hf, 8'h00);
      wr(4'h0, 8'h36);
      wr(4'h1, 8'h43);
      reset(1'b0);
      rd(4'h0, 8'h34);
      rd(4'h1, 8'h43, 8'hf3);
      rd(4'h5, 8'hff);
      periodTimerDisable <= 1'b1;
      wideTimerDisable <= 1'b1;
      repeat (4) @(posedge clock);
      rd(4'h6, 8'h00);
      rd(4'h0, 8'h00);
      periodTimerDisable <= 1'b0;
      wideTimerDisable <= 1'b0;
      $display("test reset done");
      wr(4'h5, 8'h02);
      for (int c = 0; c < 4; c++)
      begin
         wr(4'h6, {6'h01, c[1:0]});
         waitHi(periodMatch, 1000, n);
         waitHi(periodMatch, 1000, n);
         waitHi(periodMatch, 1000, n);
         check(n, 12 * (c == 0 ? 1 : c == 1 ? 4 : 16));
      end
      wr(4'h5, 8'h00);
      wr(4'h8, 8'h0c);
      @(negedge clock);
      check(periodMatchHighPrio, 1'b1);
      foreach (pv[i])
      begin
         wr(4'h6, 8'h00);
         wr(4'h4, 8'h00);
         wr(4'h7, 8'h00);
         serialModeSelect <= pv[i][3:0];
         wr(4'h6, {1'b0, pv[i][3:0], 3'b100});
         n = 0;
         for (int k = 0; k < 200 && periodMatchIrq !== 1'b1; k++)
         begin
            @(negedge clock);
            n += periodMatch;
         end
         check(n, pv[i] + 1);
      end
      wr(4'h6, 8'h00);
      waitHi(periodMatch, 40, n);
      check(n, 40);
      seed = xs(seed);
      wr(4'h4, seed[7:0]);
      wr(4'h5, seed[15:8]);
      wr(4'h6, 8'h7b);
      rd(4'h4, seed[7:0]);
      rd(4'h5, seed[15:8]);
      rd(4'h6, 8'h7b);
      sleep <= 1'b1;
      wr(4'h6, 8'h04);
      wr(4'h4, 8'h05);
      repeat (40) @(posedge clock);
      rd(4'h4, 8'h05);
      sleep <= 1'b0;
      wr(4'h6, 8'h00);
      $display("test period done");
      wr(4'h8, 8'h02);
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 4; c++)
         begin
            e = 16 * (1 << c) * (s ? 1 : 4);
            wr(4'h0, {s[1:0], c[1:0], 4'h2});
            wr(4'h3, 8'hff);
            wr(4'h2, 8'hf0);
            wr(4'h7, 8'h00);
            wr(4'h0, {s[1:0], c[1:0], 4'h3});
            waitHi(rolloverIrq, 2000, n);
            check(n > e * 15 / 16 - 3 && n < e + 8, 1'b1);
         end
      wr(4'h0, 8'h42);
      rd(4'h2, 8'h00, 8'h00);
      rd(4'h3, 8'h00);
      wr(4'h3, 8'h5a);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'ha5);
      rd(4'h2, 8'h00, 8'h00);
      rd(4'h3, 8'h5a);
      foreach (ec[i])
      begin
         wr(4'h0, 8'h02);
         wr(4'h3, 8'h00);
         wr(4'h2, 8'h00);
         wr(4'h0, ec[i]);
         go <= 1'b1;
         waitHi(pinsDone, 200, n);
         go <= 1'b0;
         wr(4'h0, 8'h02);
         rd(4'h2, ec[i][6] ? 8'h00 : 8'h09);
      end
      $display("test wide done");
      wr(4'h8, 8'h03);
      wr(4'h0, 8'h43);
      wr(4'h1, 8'hc0);
      wr(4'h3, 8'hff);
      wr(4'h2, 8'hf0);
      wr(4'h7, 8'h00);
      waitHi(rolloverIrq, 100, n);
      check(n, 100);
      gateLevel <= 1'b1;
      waitHi(rolloverIrq, 40, n);
      check(n < 40, 1'b1);
      rd(4'h1, 8'hc4, 8'hf7);
      gateLevel <= 1'b0;
      waitHi(gateEventIrq, 8, n);
      check(gateEventIrq, 1'b1);
      wr(4'h1, 8'h80);
      wr(4'h3, 8'hff);
      wr(4'h2, 8'hf0);
      wr(4'h7, 8'h00);
      waitHi(rolloverIrq, 40, n);
      check(n < 40, 1'b1);
      gateLevel <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         wr(4'h1, {6'h00, s[1:0]});
         repeat (4) @(posedge clock);
         rd(4'h1, {5'h00, s == 1 || s == 3, s[1:0]}, 8'hf7);
      end
      gateLevel <= 1'b0;
      wr(4'h1, 8'hc0);
      repeat (4) @(posedge clock);
      wr(4'h1, 8'he0);
      gateLevel <= 1'b1;
      repeat (6) @(posedge clock);
      gateLevel <= 1'b0;
      repeat (6) @(posedge clock);
      rd(4'h1, 8'he4, 8'hf7);
      wr(4'h1, 8'hc0);
      wr(4'h1, 8'he0);
      rd(4'h1, 8'he0, 8'hf7);
      wr(4'h1, 8'hd8);
      rd(4'h1, 8'hd8, 8'hfb);
      gateLevel <= 1'b1;
      repeat (10) @(posedge clock);
      gateLevel <= 1'b0;
      repeat (6) @(posedge clock);
      rd(4'h1, 8'hd0, 8'hfb);
      wr(4'h1, 8'hd8);
      wr(4'h1, 8'hc8);
      rd(4'h1, 8'hc0, 8'hfb);
      $display("test gate done");
      repeat (4) @(posedge clock);
      complete_run();
   end

   initial
   begin
      repeat (30000) @(posedge clock);
      fail_count++;
      complete_run();
   end
endmodule : gtp_timer_block_tb_top
